// File: bct_pkg.sv
package bct_pkg;

  // ---------------------------------------------------------------
  // Bus cycle state machine
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    BCT_IDLE = 4'b0000,
    BCT_T1   = 4'b0001,
    BCT_HOLD = 4'b0010,
    BCT_T2   = 4'b0011,
    BCT_TD   = 4'b0100,
    BCT_TW   = 4'b0101,
    BCT_T3   = 4'b0110,
    BCT_T4   = 4'b0111
  } bct_state_e;

  // ---------------------------------------------------------------
  // Counts, widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BCT_WAIT_W = 4;
  localparam logic [2:0] BCT_TD_LAST = 3'h4;
  localparam logic [2:0] BCT_TD_SAMPLE = 3'h2;
  localparam logic [2:0] BCT_TD_RESET = 3'h0;
  localparam logic [3:0] BCT_WAIT_RESET = 4'h0;

endpackage

// File: bct_bus_cycle_timing.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Low reset request forces system reset output low.
// - System reset releases on first phase-one rise after request returns high.
// - Phase sync input sampled on every oscillator rising edge.
// - Sync high during reset with phase clock high delays phase clock one cycle.
// - Sync input high floats read and write strobes; low drives them.
// - One-edge sync pulse forces phase clock high next.
// - Cycle starts on cycle-start strobe; direction input picks read or write.
// - Read and write strobes never asserted together.
// - Buffer enable asserts half a period later on reads than writes in plain cycles.
// - State marker low from T2 start until T4 start.
// - Plain cycle lasts four phase-one cycles; waits add at least one.
// - Ready low exactly while hold, delay or wait states are inserted.
// - Normal waits begin on wait inputs low at mid T2.
// - Peripheral input low at T2 start inserts five delay states.
// - Peripheral cycles reshape strobes for longer setup, starting them at TD1; they still end with T3.
// - Continuous wait low at end of T1 holds cycle while low.
// - Cycle hold keeps strobes, marker, buffer inactive and ready low.
// - Priority: hold, peripheral, continuous wait, counted wait.
// - Leaving hold, peripheral input is sampled.
// - Waits sampled mid T2, or three cycles later in peripheral cycles.
// - Counter reloads while continuous wait low, decrements while high except on the first high rise after a low sample.
// - Continuous wait sampled low always inserts at least one wait.
module bct_bus_cycle_timing
  import bct_pkg::*;
(
  // Clock and reset (clock_in is the oscillator input)
  input wire logic clock_in,
  input wire logic reset_in,
  // Reset and phase control
  input wire logic reset_request_in_n,
  input wire logic strobe_enable_phase_sync_in,
  output logic system_reset_out_n,
  output logic system_phase_clock_out,
  output logic cpu_phase_one_clock_out,
  // CPU bus
  input wire logic cycle_start_strobe_n_in,
  input wire logic transfer_direction_in_n,
  input wire logic continuous_wait_n_in,
  input wire logic [3:0] counted_wait_n_in,
  input wire logic slow_peripheral_cycle_n_in,
  // Strobes and status (read and write strobes are three-state pins as out plus enable)
  output logic read_strobe_n_out,
  output logic read_strobe_oe_out,
  output logic write_strobe_n_out,
  output logic write_strobe_oe_out,
  output logic buffer_enable_n_out,
  output logic state_marker_out_n,
  output logic ready_out
);

  // ---------------------------------------------------------------
  // Phase and reset
  // ---------------------------------------------------------------
  logic phase_q, phase_d;
  logic rst_q, rst_d;
  logic sync_q, sync_d;
  logic phase_rise;

  always_comb begin
    sync_d = strobe_enable_phase_sync_in;
    phase_d = ~phase_q;
    // Sync forces high: from low it locks phase, from high it delays one edge
    if (strobe_enable_phase_sync_in) begin
      phase_d = 1'b1;
    end
    rst_d = rst_q;
    if (!reset_request_in_n) begin
      rst_d = 1'b0;
    end else if (phase_d && !phase_q) begin
      rst_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      phase_q <= 1'b0;
      rst_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      rst_q <= rst_d;
      sync_q <= sync_d;
    end
  end

  // One oscillator cycle per half of the phase-one clock
  assign phase_rise = ~phase_q;

  // ---------------------------------------------------------------
  // Bus cycle sequencer (advances at each phase-one rise)
  // ---------------------------------------------------------------
  bct_state_e st_q, st_d;
  logic read_q, read_d;
  logic per_q, per_d;
  logic cw_q, cw_d;
  logic [2:0] td_q, td_d;
  logic [BCT_WAIT_W-1:0] cnt_q, cnt_d;
  logic [BCT_WAIT_W-1:0] wait_val;

  assign wait_val = ~counted_wait_n_in;

  always_comb begin
    st_d = st_q;
    read_d = read_q;
    per_d = per_q;
    cw_d = cw_q;
    td_d = td_q;
    cnt_d = cnt_q;
    if (!rst_q) begin
      st_d = BCT_IDLE;
      per_d = 1'b0;
      cw_d = 1'b0;
    end else if (phase_rise) begin
      case (st_q)
        BCT_IDLE: begin
          if (!cycle_start_strobe_n_in) begin
            st_d = BCT_T1;
            read_d = ~transfer_direction_in_n;
            per_d = 1'b0;
          end
        end
        BCT_T1, BCT_HOLD: begin
          if (!continuous_wait_n_in) begin
            st_d = BCT_HOLD;
          end else begin
            st_d = BCT_T2;
            per_d = ~slow_peripheral_cycle_n_in;
          end
        end
        BCT_T2: begin
          td_d = BCT_TD_RESET;
          if (per_q) begin
            st_d = BCT_TD;
          end else if (cw_q || cnt_q != BCT_WAIT_RESET) begin
            st_d = BCT_TW;
          end else begin
            st_d = BCT_T3;
          end
        end
        BCT_TD: begin
          td_d = td_q + 3'h1;
          if (td_q == BCT_TD_LAST) begin
            st_d = (cw_q || cnt_q != BCT_WAIT_RESET) ? BCT_TW : BCT_T3;
          end
        end
        BCT_TW: begin
          if (!continuous_wait_n_in) begin
            cnt_d = wait_val;
            cw_d = 1'b1;
          end else if (cw_q) begin
            cw_d = 1'b0;
            if (cnt_q == BCT_WAIT_RESET) begin
              st_d = BCT_T3;
            end
          end else if (cnt_q <= 4'h1) begin
            cnt_d = BCT_WAIT_RESET;
            st_d = BCT_T3;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        BCT_T3: st_d = BCT_T4;
        BCT_T4: st_d = BCT_IDLE;
        default: st_d = BCT_IDLE;
      endcase
    end else if (st_q == BCT_T2 && !per_q) begin
      // Mid-state sample; the rise ending T2 only acts on it
      cw_d = ~continuous_wait_n_in;
      cnt_d = wait_val;
    end else if (st_q == BCT_TD && td_q == BCT_TD_SAMPLE) begin
      cw_d = ~continuous_wait_n_in;
      cnt_d = wait_val;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_q <= BCT_IDLE;
      read_q <= 1'b0;
      per_q <= 1'b0;
      cw_q <= 1'b0;
      td_q <= BCT_TD_RESET;
      cnt_q <= BCT_WAIT_RESET;
    end else begin
      st_q <= st_d;
      read_q <= read_d;
      per_q <= per_d;
      cw_q <= cw_d;
      td_q <= td_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Output strobes, registered
  // ---------------------------------------------------------------
  logic rd_q, rd_d, wr_q, wr_d, dbe_q, dbe_d, tso_q, tso_d, rdy_q, rdy_d;
  logic active;

  // Strobes live over T2..T3; peripheral cycles only from TD1 on
  always_comb begin
    active = (st_d == BCT_T2 && !per_d) || st_d == BCT_TW || st_d == BCT_T3
             || (st_d == BCT_TD && td_d != BCT_TD_RESET);
    rd_d = ~(active && read_d);
    wr_d = ~(active && !read_d);
    // In plain cycles reads open the buffer one half period later
    dbe_d = ~((st_d == BCT_T2 && !read_d) || (active && (!read_d || phase_q))
              || (active && st_d != BCT_T2));
    tso_d = ~(st_d == BCT_T2 || st_d == BCT_TD || st_d == BCT_TW
              || st_d == BCT_T3);
    rdy_d = ~(st_d == BCT_HOLD || st_d == BCT_TD || st_d == BCT_TW);
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      dbe_q <= 1'b1;
      tso_q <= 1'b1;
      rdy_q <= 1'b1;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      dbe_q <= dbe_d;
      tso_q <= tso_d;
      rdy_q <= rdy_d;
    end
  end

  assign system_reset_out_n = rst_q;
  assign system_phase_clock_out = phase_q;
  assign cpu_phase_one_clock_out = phase_q;
  assign read_strobe_n_out = rd_q;
  assign write_strobe_n_out = wr_q;
  assign read_strobe_oe_out = ~sync_q;
  assign write_strobe_oe_out = ~sync_q;
  assign buffer_enable_n_out = dbe_q;
  assign state_marker_out_n = tso_q;
  assign ready_out = rdy_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  AST_RESET_HOLD: assert property (!reset_request_in_n |=> !system_reset_out_n)
    else $error("reset output not asserted");
  AST_RESET_REL: assert property ($rose(system_reset_out_n) |-> system_phase_clock_out)
    else $error("reset released off phase edge");
  AST_SYNC_PULSE: assert property (strobe_enable_phase_sync_in |=> system_phase_clock_out)
    else $error("phase clock not forced high");
  AST_TRISTATE: assert property (strobe_enable_phase_sync_in |=> !read_strobe_oe_out)
    else $error("strobes driven while sync high");
  AST_EXCL: assert property (!(read_strobe_n_out == 1'b0 && write_strobe_n_out == 1'b0))
    else $error("read and write together");
  AST_HOLD_QUIET: assert property (st_q == BCT_HOLD |->
      read_strobe_n_out && write_strobe_n_out && buffer_enable_n_out
      && state_marker_out_n && !ready_out)
    else $error("hold not quiet");
  sequence s_two_waits;
    st_q == BCT_TW ##1 st_q == BCT_TW;
  endsequence
  AST_READY: assert property (s_two_waits |-> !ready_out)
    else $error("ready high during wait");
  AST_TSO_T2: assert property ($rose(st_q == BCT_T2) |-> !state_marker_out_n)
    else $error("marker not low in T2");
  AST_T4_END: assert property (st_q == BCT_T4 && phase_rise |=> st_q == BCT_IDLE)
    else $error("cycle did not end after T4");
  AST_PER_TD: assert property (st_q == BCT_T2 && per_q && phase_rise |=> st_q == BCT_TD)
    else $error("peripheral states skipped");

  // ---------------------------------------------------------------
  // Extension and strobe shape checks
  // ---------------------------------------------------------------
  // Mid-T2 sample with continuous wait low
  sequence s_t2_mid_continuous_wait_n;
    st_q == BCT_T2 && !phase_rise && !per_q && !continuous_wait_n_in
    && system_reset_out_n;
  endsequence
  // Five delay states, two oscillator edges each
  sequence s_td_span;
    (st_q == BCT_TD)[*8] ##1 (st_q == BCT_TD)[*2];
  endsequence

  AST_HOLD_ENTRY: assert property (st_q == BCT_T1 && phase_rise &&
      !continuous_wait_n_in && system_reset_out_n |=> st_q == BCT_HOLD)
    else $error("cycle hold not entered");
  AST_HOLD_STAY: assert property (st_q == BCT_HOLD &&
      !continuous_wait_n_in && system_reset_out_n |=> st_q == BCT_HOLD)
    else $error("cycle hold left early");
  AST_CW_WAIT: assert property (s_t2_mid_continuous_wait_n ##1 phase_rise |=>
      st_q == BCT_TW)
    else $error("no wait after continuous wait");
  AST_TD_SPAN: assert property ($rose(st_q == BCT_TD) |->
      s_td_span ##1 st_q != BCT_TD)
    else $error("delay states wrong length");
  AST_TD0_QUIET: assert property (st_q == BCT_TD && td_q == BCT_TD_RESET |->
      read_strobe_n_out && write_strobe_n_out)
    else $error("strobe active in first delay state");
  AST_MARK_T4: assert property (st_q == BCT_T4 |-> state_marker_out_n)
    else $error("marker low in T4");
  AST_RDY_IDLE: assert property (st_q == BCT_IDLE || st_q == BCT_T1 |-> ready_out)
    else $error("ready low with no wait");
  AST_PHASE_RUN: assert property (!strobe_enable_phase_sync_in |=>
      system_phase_clock_out != $past(system_phase_clock_out))
    else $error("phase clock did not toggle");
  AST_BUF_READ: assert property ($rose(st_q == BCT_T2) && read_q |->
      buffer_enable_n_out)
    else $error("read buffer enabled too early");
  AST_BUF_WRITE: assert property ($rose(st_q == BCT_T2) && !read_q |->
      !buffer_enable_n_out)
    else $error("write buffer not enabled");

endmodule // bct_bus_cycle_timing

// File: bct_cpu_model.sv
`timescale 1ns/100ps
module bct_cpu_model (
  // Clock and phase
  input wire logic clock_in,
  input wire logic phase_in,
  // Commands from bench
  input wire logic req_in,
  input wire logic write_in,
  // CPU bus
  output logic cycle_start_strobe_n_out,
  output logic transfer_direction_n_out
);
  int cnt = 0;
  logic req_s;
  initial begin
    cycle_start_strobe_n_out = 1'b1;
    transfer_direction_n_out = 1'b0;
  end
  // ----------------------------------------
  // Strobe spans exactly one phase rise
  // ----------------------------------------
  always @(posedge clock_in) begin
    // Latch the request on the edge, before the bench moves it
    req_s = req_in;
    #1;
    if (cnt != 0) begin
      cnt = cnt - 1;
      if (cnt == 0) cycle_start_strobe_n_out = 1'b1;
    end else if (req_s && !phase_in) begin
      cycle_start_strobe_n_out = 1'b0;
      transfer_direction_n_out = write_in;
      cnt = 2;
    end
  end
endmodule // bct_cpu_model

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic rrq_n = 1'b0, sync = 1'b0, cwn = 1'b1, per_n = 1'b1, req = 1'b0, wr = 1'b0;
  logic [3:0] cnt_n = 4'hF;
  logic srst_n, ph, ph1, cyc_n, dir_n, rd_n, rd_oe, wr_n, wr_oe, be_n, mk_n, rdy;
  int error_cnt = 0, checks_done = 0, mk, rl, ov, hb, db, dbr, rdl, wrl;
  always #20 clock_in = ~clock_in;
  bct_bus_cycle_timing uut (.clock_in(clock_in), .reset_in(reset_in),
    .reset_request_in_n(rrq_n), .strobe_enable_phase_sync_in(sync),
    .system_reset_out_n(srst_n), .system_phase_clock_out(ph), .cpu_phase_one_clock_out(ph1),
    .cycle_start_strobe_n_in(cyc_n), .transfer_direction_in_n(dir_n),
    .continuous_wait_n_in(cwn), .counted_wait_n_in(cnt_n),
    .slow_peripheral_cycle_n_in(per_n), .read_strobe_n_out(rd_n), .read_strobe_oe_out(rd_oe),
    .write_strobe_n_out(wr_n), .write_strobe_oe_out(wr_oe), .buffer_enable_n_out(be_n),
    .state_marker_out_n(mk_n), .ready_out(rdy));
  bct_cpu_model cpu (.clock_in(clock_in), .phase_in(ph), .req_in(req), .write_in(wr),
    .cycle_start_strobe_n_out(cyc_n), .transfer_direction_n_out(dir_n));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_in);
      #1;
    end
  endtask
  // One bus cycle; window covers the longest cycle used here
  task automatic meas(input logic w, input int hold, input logic pulse);
    bit done;
    done = 0;
    {mk, rl, ov, hb, rdl, wrl} = '0;
    db = -1;
    wr = w;
    req = 1'b1;
    for (int i = 0; i < 60; i++) begin
      step(1);
      // Two latched edges always cover one phase-one rise
      if (i == 1) req = 1'b0;
      if (i == hold) cwn = 1'b1;
      if (pulse && !done && !mk_n) begin
        cwn = 1'b0;
        done = 1;
      end else if (pulse && done) cwn = 1'b1;
      mk += !mk_n;
      rl += !rdy;
      rdl += !rd_n;
      wrl += !wr_n;
      ov += (!rd_n && !wr_n);
      hb += (!rdy && (!mk_n || !rd_n || !wr_n || !be_n));
      if (!be_n && db < 0) db = i;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    step(20);
    reset_in = 1'b0;
    step(4);
    chk("rst_held", srst_n, 1'b0);
    rrq_n = 1'b1;
    step(4);
    chk("rst_rel", srst_n, 1'b1);
  endtask
  task t_read;
    meas(1'b0, -1, 1'b0);
    dbr = db;
    chk("rd_marker", mk, 4);
    chk("rd_ready", rl, 0);
    chk("rd_wr_idle", wrl, 0);
    chk("rd_seen", rdl != 0, 1);
    chk("rd_overlap", ov, 0);
  endtask
  task t_write;
    meas(1'b1, -1, 1'b0);
    chk("wr_rd_idle", rdl, 0);
    chk("wr_seen", wrl != 0, 1);
    chk("dbe_delay", dbr - db, 1);
  endtask
  task t_counted;
    cnt_n = ~4'h1;
    meas(1'b0, -1, 1'b0);
    chk("w1_marker", mk, 6);
    chk("w1_ready", rl, 2);
    cnt_n = ~4'hF;
    meas(1'b1, -1, 1'b0);
    chk("w15_marker", mk, 34);
    chk("w15_ready", rl, 30);
    chk("w15_overlap", ov, 0);
    cnt_n = 4'hF;
  endtask
  task t_per;
    per_n = 1'b0;
    meas(1'b0, -1, 1'b0);
    per_n = 1'b1;
    chk("per_marker", mk, 14);
    chk("per_ready", rl, 10);
  endtask
  task t_cwpulse;
    meas(1'b0, -1, 1'b1);
    chk("cw_ready", rl, 2);
    chk("cw_marker", mk, 6);
  endtask
  task t_hold;
    cwn = 1'b0;
    meas(1'b1, 6, 1'b0);
    chk("hold_quiet", hb, 0);
    chk("hold_ready", rl != 0, 1);
    chk("hold_marker", mk, 4);
    cwn = 1'b0;
    per_n = 1'b0;
    meas(1'b0, 6, 1'b0);
    per_n = 1'b1;
    chk("hold_per", mk, 14);
  endtask
  task t_sync;
    // One-edge pulses only, second one lands with the phase high
    repeat (2) begin
      sync = 1'b1;
      step(1);
      sync = 1'b0;
      chk("sync_phase", ph, 1'b1);
      chk("sync_ph1", ph1, 1'b1);
      chk("sync_float", {rd_oe, wr_oe}, 2'b00);
      step(2);
      chk("sync_drive", {rd_oe, wr_oe}, 2'b11);
    end
  endtask
  initial begin
    t_reset;
    step(4);
    t_read;
    t_write;
    t_counted;
    t_per;
    t_cwpulse;
    t_hold;
    t_sync;
    report_and_stop;
  end
  // Run needs well under 800 cycles
  initial begin
    #400000;
    error_cnt++;
    report_and_stop;
  end
endmodule // tb
